/* rxsr_pkg.sv */
// Package with register map, field layout and status types for the receiver status registers.
// Notes on behaviour
// - State code in bits 4:0, upper bits zero.
// - Register access never reports sleep or oscillator-off.
// - CRC bit set on match, cleared on receive entry.
// - Carrier bit follows detection, cleared entering idle.
// - Frame delimiter rises on sync, falls at end.
// - Delimiter also falls on filter drop or overflow.
// - Bit 2 shows un-inverted second output value.
// - Bit 0 shows un-inverted first output value.
// - FIFO status bits 6:0 hold byte count.
// - FIFO status bit 7 flags overflow.
// - Strength register shows eight-bit signal strength.
package rxsr_pkg;
  localparam logic [5:0] OFS_SIGNAL_STRENGTH  = 6'h34;
  localparam logic [5:0] OFS_RADIO_FSM_STATE  = 6'h35;
  localparam logic [5:0] OFS_PACKET_PIN_STAT  = 6'h38;
  localparam logic [5:0] OFS_RX_FIFO_LEVEL    = 6'h3b;
  localparam int         POS_CRC_MATCH        = 7;
  localparam int         POS_CARRIER          = 6;
  localparam int         POS_FRAME_DELIM      = 3;
  localparam int         POS_OUTPUT_TWO       = 2;
  localparam int         POS_OUTPUT_ZERO      = 0;
  localparam int         POS_OVERRUN          = 7;
  localparam logic [4:0] STATE_SLEEP          = 5'h00;
  localparam logic [4:0] STATE_IDLE           = 5'h01;
  localparam logic [4:0] STATE_OSC_OFF        = 5'h02;
  localparam logic [4:0] STATE_RX             = 5'h0d;
  localparam logic [4:0] STATE_RX_RESTART     = 5'h0f;
  localparam logic [4:0] STATE_OVERRUN        = 5'h11;
  localparam logic [7:0] RESET_DATA           = 8'h00;
  localparam logic [4:0] RESET_STATE          = 5'h01;

  // Per-cycle events from the packet handler and demodulator.
  typedef struct packed {
    logic crc_match;
    logic crc_fail;
    logic carrier;
    logic sync_found;
    logic packet_end;
    logic filter_drop;
  } rxsr_pkt_ev_t;

  // Receive FIFO status from the datapath.
  typedef struct packed {
    logic       overrun;
    logic [6:0] count;
  } rxsr_fifo_t;
endpackage

/* rxsr_status_regs.sv */
// Read-only status register group of the packet receiver.
`timescale 1ns/1ps
`default_nettype none
module rxsr_status_regs (
  input  wire logic                  I_CLK,
  input  wire logic                  I_ARST_N,
  input  wire logic                  I_CE,
  input  wire logic [5:0]            I_RD_ADDR,
  input  wire logic                  I_RD_EN,
  input  wire logic                  I_ACCESS_ACTIVE,
  input  wire logic [4:0]            I_RADIO_STATE,
  input  wire logic [7:0]            I_SIGNAL_STRENGTH,
  input  wire rxsr_pkg::rxsr_pkt_ev_t I_PKT_EV,
  input  wire rxsr_pkg::rxsr_fifo_t  I_FIFO,
  input  wire logic                  I_OUTPUT_TWO_RAW,
  input  wire logic                  I_OUTPUT_ZERO_RAW,
  output logic [7:0]                 O_RD_DATA,
  output logic                       O_RD_VALID
);
  // Captured status, one flop stage behind the sources; synced pin levels are two stages behind.
  logic [4:0] state_q;
  logic [4:0] state_prev_q;
  logic [7:0] strength_q;
  logic       crc_q;
  logic       carrier_q;
  logic       delim_q;
  logic [7:0] fifo_q;
  wire  logic [1:0] pin_raw;
  wire  logic [1:0] pin_sync;

  // Bit 1 carries output two and bit 0 output zero.
  assign pin_raw = {I_OUTPUT_TWO_RAW, I_OUTPUT_ZERO_RAW};

  // Pin levels may arrive from pad logic, so each passes two flops first.
  for (genvar p = 0; p < 2; p++) begin : g_pin_sync
    logic meta_q;
    logic sync_q;
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
        meta_q <= 1'b0;
        sync_q <= 1'b0;
      end else if (I_CE) begin
        meta_q <= pin_raw[p];
        sync_q <= meta_q;
      end
    end
    assign pin_sync[p] = sync_q;
  end

  // State decoding of the incoming radio state code.
  wire logic       enter_rx   = (I_RADIO_STATE == rxsr_pkg::STATE_RX) &&
                                (state_prev_q != rxsr_pkg::STATE_RX);
  wire logic       restart_rx = (I_RADIO_STATE == rxsr_pkg::STATE_RX_RESTART);
  wire logic       enter_idle = (I_RADIO_STATE == rxsr_pkg::STATE_IDLE);
  wire logic       overrun_st = (I_RADIO_STATE == rxsr_pkg::STATE_OVERRUN);
  wire logic       sleepy     = (I_RADIO_STATE == rxsr_pkg::STATE_SLEEP) ||
                                (I_RADIO_STATE == rxsr_pkg::STATE_OSC_OFF);

  // An access wakes the core, so a sleep code seen then reads as idle.
  wire logic [4:0] state_d    = (sleepy && I_ACCESS_ACTIVE) ? rxsr_pkg::STATE_IDLE
                                                            : I_RADIO_STATE;

  // The read path maps sleep codes again, so a read without access still shows idle.
  wire logic       rd_sleepy  = (state_q == rxsr_pkg::STATE_SLEEP) ||
                                (state_q == rxsr_pkg::STATE_OSC_OFF);
  wire logic [4:0] state_rd   = rd_sleepy ? rxsr_pkg::STATE_IDLE : state_q;

  // A match in the same cycle as a clear wins, since it reports the newest packet.
  wire logic       crc_clr    = enter_rx || restart_rx || I_PKT_EV.crc_fail;
  wire logic       crc_d      = I_PKT_EV.crc_match ? 1'b1 :
                                crc_clr            ? 1'b0 : crc_q;
  wire logic       carrier_d  = enter_idle ? 1'b0 : I_PKT_EV.carrier;
  wire logic       delim_clr  = I_PKT_EV.packet_end || I_PKT_EV.filter_drop || overrun_st;
  wire logic       delim_set  = I_PKT_EV.sync_found;
  wire logic       delim_d    = delim_clr ? 1'b0 : (delim_set ? 1'b1 : delim_q);
  wire logic [7:0] fifo_d     = {I_FIFO.overrun, I_FIFO.count};

  // Packet and pin word; reserved and unused bits read zero.
  wire logic [7:0] pkt_word   = {crc_q, carrier_q, 2'b00, delim_q, pin_sync[1], 1'b0, pin_sync[0]};

  // Address decode of the four status registers.
  wire logic       hit_str    = (I_RD_ADDR == rxsr_pkg::OFS_SIGNAL_STRENGTH);
  wire logic       hit_state  = (I_RD_ADDR == rxsr_pkg::OFS_RADIO_FSM_STATE);
  wire logic       hit_pkt    = (I_RD_ADDR == rxsr_pkg::OFS_PACKET_PIN_STAT);
  wire logic       hit_fifo   = (I_RD_ADDR == rxsr_pkg::OFS_RX_FIFO_LEVEL);
  wire logic       hit_none   = !(hit_str || hit_state || hit_pkt || hit_fifo);
  wire logic [7:0] rd_mux     =
    hit_str   ? strength_q :
    hit_state ? {3'b000, state_rd} :
    hit_pkt   ? pkt_word :
    hit_fifo  ? fifo_q : rxsr_pkg::RESET_DATA;

  // Radio state capture.
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      state_q      <= rxsr_pkg::RESET_STATE;
      state_prev_q <= rxsr_pkg::RESET_STATE;
    end else if (I_CE) begin
      state_q      <= state_d;
      state_prev_q <= I_RADIO_STATE;
    end
  end

  // Strength and FIFO status capture.
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      strength_q <= rxsr_pkg::RESET_DATA;
      fifo_q     <= rxsr_pkg::RESET_DATA;
    end else if (I_CE) begin
      strength_q <= I_SIGNAL_STRENGTH;
      fifo_q     <= fifo_d;
    end
  end

  // Read strobes only select data; no status flop looks at them.
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      crc_q     <= 1'b0;
      carrier_q <= 1'b0;
      delim_q   <= 1'b0;
    end else if (I_CE) begin
      crc_q     <= crc_d;
      carrier_q <= carrier_d;
      delim_q   <= delim_d;
    end
  end

  // Read port; data holds until the next read is taken.
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_RD_DATA  <= rxsr_pkg::RESET_DATA;
      O_RD_VALID <= 1'b0;
    end else if (I_CE) begin
      O_RD_DATA  <= I_RD_EN ? rd_mux : O_RD_DATA;
      O_RD_VALID <= I_RD_EN;
    end
  end

  chk_state_no_sleep: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    (I_CE && I_ACCESS_ACTIVE && sleepy) |=> (state_q == rxsr_pkg::STATE_IDLE))
    else $error("Sleep code reported during access.");
  chk_state_read_awake: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    (I_CE && I_RD_EN && hit_state)
      |=> (O_RD_DATA[4:0] != rxsr_pkg::STATE_SLEEP && O_RD_DATA[4:0] != rxsr_pkg::STATE_OSC_OFF))
    else $error("Sleep code returned by a read.");
  chk_state_upper_zero: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    (I_CE && I_RD_EN && hit_state)
      |=> (O_RD_DATA[7:5] == 3'b000 && O_RD_DATA[4:0] == $past(state_rd)))
    else $error("State read wrong.");
  chk_state_follow: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    (I_CE && !sleepy) |=> (state_q == $past(I_RADIO_STATE)))
    else $error("State code not captured.");
  chk_crc_set: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    (I_CE && I_PKT_EV.crc_match) |=> crc_q)
    else $error("CRC flag not set.");
  chk_crc_clear: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    (I_CE && restart_rx && !I_PKT_EV.crc_match) |=> !crc_q)
    else $error("CRC flag not cleared on restart.");
  chk_crc_enter: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    (I_CE && enter_rx && !I_PKT_EV.crc_match) |=> !crc_q)
    else $error("CRC flag not cleared on receive entry.");
  chk_carrier_idle: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    (I_CE && enter_idle) |=> !carrier_q)
    else $error("Carrier flag held in idle.");
  chk_carrier_follow: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    (I_CE && !enter_idle) |=> (carrier_q == $past(I_PKT_EV.carrier)))
    else $error("Carrier flag not following detection.");
  chk_delim_rise: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    (I_CE && delim_set && !delim_clr) |=> delim_q)
    else $error("Delimiter missed sync.");
  chk_delim_end: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    (I_CE && I_PKT_EV.packet_end) |=> !delim_q)
    else $error("Delimiter held after packet end.");
  chk_delim_drop: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    (I_CE && (I_PKT_EV.filter_drop || overrun_st)) |=> !delim_q)
    else $error("Delimiter held after drop.");
  chk_pin_two_pipe: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    (I_CE [*3]) |-> (pin_sync[1] == $past(I_OUTPUT_TWO_RAW, 2)))
    else $error("Output two level wrong.");
  chk_pin_zero_pipe: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    (I_CE [*3]) |-> (pin_sync[0] == $past(I_OUTPUT_ZERO_RAW, 2)))
    else $error("Output zero level wrong.");
  chk_pkt_read: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    (I_CE && I_RD_EN && hit_pkt)
      |=> (O_RD_DATA[rxsr_pkg::POS_OUTPUT_TWO] == $past(pin_sync[1]) &&
           O_RD_DATA[rxsr_pkg::POS_OUTPUT_ZERO] == $past(pin_sync[0]) &&
           O_RD_DATA[rxsr_pkg::POS_CRC_MATCH] == $past(crc_q) &&
           O_RD_DATA[rxsr_pkg::POS_CARRIER] == $past(carrier_q) &&
           O_RD_DATA[rxsr_pkg::POS_FRAME_DELIM] == $past(delim_q) &&
           O_RD_DATA[5:4] == 2'b00 && O_RD_DATA[1] == 1'b0))
    else $error("Packet status read wrong.");
  chk_fifo_read: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    (I_CE && I_RD_EN && hit_fifo) |=> (O_RD_DATA == $past(fifo_q)))
    else $error("FIFO level read wrong.");
  chk_fifo_count: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    I_CE |=> (fifo_q[6:0] == $past(I_FIFO.count)))
    else $error("FIFO count not captured.");
  chk_fifo_overrun: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    (I_CE && I_FIFO.overrun) |=> fifo_q[rxsr_pkg::POS_OVERRUN])
    else $error("Overrun not captured.");
  chk_strength_read: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    (I_CE && I_RD_EN && hit_str) |=> (O_RD_DATA == $past(strength_q)))
    else $error("Strength read wrong.");
  chk_strength_follow: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    I_CE |=> (strength_q == $past(I_SIGNAL_STRENGTH)))
    else $error("Strength not captured.");
  chk_read_no_effect: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    (I_CE && I_RD_EN && !I_PKT_EV.crc_match && !crc_clr) |=> (crc_q == $past(crc_q)))
    else $error("Read disturbed CRC flag.");
  chk_read_delim_kept: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    (I_CE && I_RD_EN && !delim_set && !delim_clr) |=> (delim_q == $past(delim_q)))
    else $error("Read disturbed delimiter flag.");
  chk_valid_pulse: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    I_CE |=> (O_RD_VALID == $past(I_RD_EN)))
    else $error("Read valid not one cycle after strobe.");
  chk_unmapped_zero: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    (I_CE && I_RD_EN && hit_none) |=> (O_RD_DATA == rxsr_pkg::RESET_DATA))
    else $error("Unmapped address returned data.");
  chk_ce_freeze: assert property (
    @(posedge I_CLK) disable iff (!I_ARST_N)
    !I_CE |=> (O_RD_DATA == $past(O_RD_DATA) && O_RD_VALID == $past(O_RD_VALID) &&
               state_q == $past(state_q) && crc_q == $past(crc_q)))
    else $error("State moved while clock enable low.");
endmodule
`default_nettype wire

/* rxsr_host_model.sv */
// Host-side model that issues single-byte status reads.
`timescale 1ns/1ps
`default_nettype none
module rxsr_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_valid,
  output logic            rd_en,
  output logic [5:0]      rd_addr,
  output logic            access
);
  initial begin
    rd_en = 1'b0;
    rd_addr = 6'h00;
    access = 1'b0;
  end
  // Output bits are only read as pin levels, never as a lock indication.
  task automatic read(input logic [5:0] a, output logic [7:0] d, output logic v);
    @(posedge clk);
    access <= 1'b1;
    repeat (2) @(posedge clk);
    rd_en <= 1'b1;
    rd_addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    @(posedge clk);
    d = rd_data;
    v = rd_valid;
    access <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* test_radio_rx_status_registers.sv */
// Testbench for the receiver status register group.
`timescale 1ns/1ps
`default_nettype none
module test_radio_rx_status_registers;
  logic       clk = 1'b0, arst_n = 1'b0, car = 1'b0, out2 = 1'b0, out0 = 1'b0;
  logic [4:0] st = 5'h01;
  logic [7:0] signal_strength = 8'h00, fifo = 8'h00, rdata;
  logic [5:0] ev = 6'h00, addr;
  logic       rd_en, acc, vld;
  int         miscompares = 0, comparisons = 0;
  rxsr_pkg::rxsr_pkt_ev_t pkt;
  assign pkt = rxsr_pkg::rxsr_pkt_ev_t'({ev[5:4], car, ev[2:0]});
  initial forever #2.5 clk = ~clk;
  rxsr_status_regs dut_u (.I_CLK(clk), .I_ARST_N(arst_n), .I_CE(1'b1),
    .I_RD_ADDR(addr), .I_RD_EN(rd_en), .I_ACCESS_ACTIVE(acc), .I_RADIO_STATE(st),
    .I_SIGNAL_STRENGTH(signal_strength), .I_PKT_EV(pkt), .I_FIFO(rxsr_pkg::rxsr_fifo_t'(fifo)),
    .I_OUTPUT_TWO_RAW(out2), .I_OUTPUT_ZERO_RAW(out0), .O_RD_DATA(rdata), .O_RD_VALID(vld));
  rxsr_host_model host_u (.clk(clk), .rd_data(rdata), .rd_valid(vld), .rd_en(rd_en),
    .rd_addr(addr), .access(acc));
  task automatic final_report;
    $display("miscompares=%0d comparisons=%0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       v;
    host_u.read(a, d, v);
    comparisons++;
    if (v !== 1'b1 || d !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t got %h expected %h", $time, d, e);
    end
  endtask
  task automatic pulse(input logic [5:0] p);
    @(posedge clk);
    ev <= p;
    @(posedge clk);
    ev <= 6'h00;
  endtask
  task automatic set_st(input logic [4:0] s);
    @(posedge clk);
    st <= s;
  endtask
  // Short tests need about 230 cycles, so this limit only trips on a hang.
  initial begin
    #50000;
    miscompares++;
    final_report;
  end
  initial begin
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    rd(6'h36, 8'h00);
    signal_strength <= 8'ha5;
    fifo <= 8'hc0;
    rd(6'h34, 8'ha5);
    rd(6'h3b, 8'hc0);
    fifo <= 8'h7f;
    rd(6'h3b, 8'h7f);
    for (int s = 0; s < 18; s++) begin
      if (s != 16) begin
        set_st(5'(s));
        rd(6'h35, (s == 0 || s == 2) ? 8'h01 : 8'(s));
      end
    end
    out2 <= 1'b1;
    rd(6'h38, 8'h04);
    out2 <= 1'b0;
    out0 <= 1'b1;
    rd(6'h38, 8'h01);
    out0 <= 1'b0;
    set_st(5'h0d);
    pulse(6'h20);
    rd(6'h38, 8'h80);
    rd(6'h38, 8'h80);
    set_st(5'h0f);
    rd(6'h38, 8'h00);
    car <= 1'b1;
    rd(6'h38, 8'h40);
    set_st(5'h01);
    rd(6'h38, 8'h00);
    car <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      set_st(5'h0d);
      pulse(6'h04);
      rd(6'h38, 8'h08);
      if (k == 2) set_st(5'h11);
      else pulse(k == 0 ? 6'h02 : 6'h01);
      rd(6'h38, 8'h00);
    end
    final_report;
  end
endmodule
`default_nettype wire
